/* logic/csel_pkg.sv */
// clock source selector: register map, field positions, reset values, source codes
// assumes an 8-bit register port from the control-port front end on the same clock
`default_nettype none
package csel_pkg;
	localparam int CSEL_AW = 8;
	localparam int CSEL_DW = 8;
	localparam logic [7:0] CSEL_REF_DSP_OFS = 8'h0d;
	localparam logic [7:0] CSEL_DAC_OSR_OFS = 8'h0e;
	localparam logic [7:0] CSEL_NCP_OFS = 8'h0f;
	localparam logic [7:0] CSEL_DSP_DAC_PIN_OFS = 8'h10;
	localparam logic [7:0] CSEL_NCP_OSR_PIN_OFS = 8'h11;
	localparam logic [7:0] CSEL_REF_PIN_OFS = 8'h12;
	localparam logic [7:0] CSEL_REF_DSP_RST = 8'h00;
	localparam logic [7:0] CSEL_DAC_OSR_RST = 8'h00;
	localparam logic [7:0] CSEL_NCP_RST = 8'h00;
	localparam logic [7:0] CSEL_DSP_DAC_PIN_RST = 8'h00;
	localparam logic [7:0] CSEL_NCP_OSR_PIN_RST = 8'h00;
	localparam logic [7:0] CSEL_REF_PIN_RST = 8'h00;
	localparam logic [7:0] CSEL_UNMAPPED_RD = 8'h00;
	// field positions: high field in bits 6-4, low field in bits 2-0
	localparam int CSEL_HI_LSB = 4;
	localparam int CSEL_LO_LSB = 0;
	localparam int CSEL_FW = 3;
	// pll reference codes
	localparam logic [2:0] CSEL_REF_MCLK = 3'h0;
	localparam logic [2:0] CSEL_REF_SCLK = 3'h1;
	localparam logic [2:0] CSEL_REF_OSC = 3'h2;
	localparam logic [2:0] CSEL_REF_GPIO = 3'h3;
	// dsp / converter divider codes; oversample and charge pump add one, 000 = converter clock
	localparam logic [2:0] CSEL_SRC_MASTER = 3'h0;
	localparam logic [2:0] CSEL_SRC_PLL = 3'h1;
	localparam logic [2:0] CSEL_SRC_OSC = 3'h2;
	localparam logic [2:0] CSEL_SRC_MCLK = 3'h3;
	localparam logic [2:0] CSEL_SRC_SCLK = 3'h4;
	localparam logic [2:0] CSEL_SRC_GPIO = 3'h5;
	localparam logic [2:0] CSEL_OSR_DAC = 3'h0;
	// pin selector codes
	localparam logic [2:0] CSEL_PIN_GPIO0 = 3'h3;
	localparam logic [2:0] CSEL_PIN_GPIO2 = 3'h5;
	localparam int CSEL_SYNC_STAGES = 2;
endpackage : csel_pkg
`default_nettype wire

/* logic/csel_sync.sv */
// csel_sync: two-stage synchroniser for a vector of independent levels
// assumes each bit changes slowly compared with the clock; bits are not coherent
`default_nettype none
module csel_sync
	import csel_pkg::*;
#(
	parameter int WIDTH = 6
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stable_q;

	// first stage feeds only the second
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_q <= '0;
			stable_q <= '0;
		end else begin
			meta_q <= async_in;
			stable_q <= meta_q;
		end
	end

	assign sync_out = stable_q;
endmodule : csel_sync
`default_nettype wire

/* logic/csel_pin_mux.sv */
// csel_pin_mux: picks one general-purpose pin level by a 3-bit pin code
// assumes synchronised pin levels; unknown codes mute (level low, ok low)
`default_nettype none
module csel_pin_mux
	import csel_pkg::*;
(
	input wire logic [2:0] pin_code,
	input wire logic gpio0_level,
	input wire logic gpio2_level,
	output logic pin_clk,
	output logic pin_ok
);
	logic is_gpio0;
	logic is_gpio2;

	assign is_gpio0 = (pin_code == CSEL_PIN_GPIO0);
	assign is_gpio2 = (pin_code == CSEL_PIN_GPIO2);
	assign pin_ok = is_gpio0 | is_gpio2;
	assign pin_clk = (is_gpio0 & gpio0_level) | (is_gpio2 & gpio2_level);
endmodule : csel_pin_mux
`default_nettype wire

/* logic/csel_top.sv */
// csel_top: clock source selection for the pll reference and four clock dividers
// assumes a same-clock register write/read port; clock sources arrive asynchronously
// and are sampled, so they must run well below half of the 10 MHz system clock
// Behaviour
// - the pll reference is the master clock pin for 0, bit clock pin for 1, oscillator for 2, chosen pin for 3, else muted.
// - in clock auto-set mode the programmed reference code is ignored and the block picks the reference itself.
// - the dsp divider source field in bits 2-0 picks master, pll, oscillator, master pin, bit clock pin or chosen pin.
// - the converter divider source field in bits 6-4 uses the same six codes as the dsp divider.
// - the oversample divider source field in bits 2-0 picks converter clock, then the six sources in order.
// - the charge pump divider source field in bits 2-0 uses the oversample divider's code set.
// - a divider whose source code is outside its set gets no clock and is reported muted.
// - one register holds the dsp pin selector in bits 6-4 and converter pin selector in bits 2-0, bits 7 and 3 reserved.
// - a pin selector picks pin 0 for code 3 and pin 2 for code 5, and mutes for any other code.
// - a second register holds the charge pump pin selector in bits 6-4 and oversample pin selector in bits 2-0.
`default_nettype none
module csel_top
	import csel_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [CSEL_AW-1:0] reg_addr,
	input wire logic [CSEL_DW-1:0] reg_wdata,
	input wire logic reg_write,
	output logic [CSEL_DW-1:0] reg_rdata,
	input wire logic mclk_pin,
	input wire logic sclk_pin,
	input wire logic gpio0_pin,
	input wire logic gpio2_pin,
	input wire logic internal_oscillator,
	input wire logic pll_clk,
	input wire logic clock_auto_set,
	input wire logic ext_clock_valid,
	output logic pll_ref_clk,
	output logic pll_ref_muted,
	output logic dsp_div_clk,
	output logic dsp_div_muted,
	output logic dac_div_clk,
	output logic dac_div_muted,
	output logic oversampling_rate_clock,
	output logic osr_div_muted,
	output logic negative_charge_pump_clock,
	output logic ncp_div_muted
);
	// result of a source pick: bit 1 = source exists, bit 0 = level
	function automatic logic [1:0] pick_div(input logic [2:0] code, input logic master, input logic pll,
		input logic osc, input logic mclk, input logic sclk, input logic gpio_clk, input logic gpio_ok);
		logic [1:0] r;
		r = 2'h0;
		case (code)
			CSEL_SRC_MASTER: r = {1'b1, master};
			CSEL_SRC_PLL: r = {1'b1, pll};
			CSEL_SRC_OSC: r = {1'b1, osc};
			CSEL_SRC_MCLK: r = {1'b1, mclk};
			CSEL_SRC_SCLK: r = {1'b1, sclk};
			CSEL_SRC_GPIO: r = {gpio_ok, gpio_clk & gpio_ok};
			default: r = 2'h0;
		endcase
		return r;
	endfunction : pick_div

	logic [7:0] ref_dsp_q;
	logic [7:0] dac_osr_q;
	logic [7:0] ncp_q;
	logic [7:0] dsp_dac_pin_q;
	logic [7:0] ncp_osr_pin_q;
	logic [7:0] ref_pin_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	// sampled sources: {pll, osc, gpio2, gpio0, sclk, mclk}
	logic [5:0] src_s;
	logic mclk_s;
	logic sclk_s;
	logic gpio0_s;
	logic gpio2_s;
	logic osc_s;
	logic pll_s;

	csel_sync #(
		.WIDTH(6)
	) u_sync (
		.clock(clock),
		.rst(rst),
		.async_in({pll_clk, internal_oscillator, gpio2_pin, gpio0_pin, sclk_pin, mclk_pin}),
		.sync_out(src_s)
	);

	assign mclk_s = src_s[0];
	assign sclk_s = src_s[1];
	assign gpio0_s = src_s[2];
	assign gpio2_s = src_s[3];
	assign osc_s = src_s[4];
	assign pll_s = src_s[5];

	// register fields
	logic [2:0] pll_reference_select;
	logic [2:0] dsp_divider_source;
	logic [2:0] converter_divider_source;
	logic [2:0] oversample_divider_source;
	logic [2:0] charge_pump_divider_source;
	logic [2:0] dsp_pin_clock_select;
	logic [2:0] converter_pin_clock_select;
	logic [2:0] charge_pump_pin_clock_select;
	logic [2:0] oversample_pin_clock_select;
	logic [2:0] ref_pin_clock_select;

	assign pll_reference_select = ref_dsp_q[CSEL_HI_LSB +: CSEL_FW];
	assign dsp_divider_source = ref_dsp_q[CSEL_LO_LSB +: CSEL_FW];
	assign converter_divider_source = dac_osr_q[CSEL_HI_LSB +: CSEL_FW];
	assign oversample_divider_source = dac_osr_q[CSEL_LO_LSB +: CSEL_FW];
	assign charge_pump_divider_source = ncp_q[CSEL_LO_LSB +: CSEL_FW];
	assign dsp_pin_clock_select = dsp_dac_pin_q[CSEL_HI_LSB +: CSEL_FW];
	assign converter_pin_clock_select = dsp_dac_pin_q[CSEL_LO_LSB +: CSEL_FW];
	assign charge_pump_pin_clock_select = ncp_osr_pin_q[CSEL_HI_LSB +: CSEL_FW];
	assign oversample_pin_clock_select = ncp_osr_pin_q[CSEL_LO_LSB +: CSEL_FW];
	assign ref_pin_clock_select = ref_pin_q[CSEL_LO_LSB +: CSEL_FW];

	// per-consumer pin choice
	logic [4:0] gpin_clk;
	logic [4:0] gpin_ok;
	logic [2:0] gpin_code [5];

	assign gpin_code[0] = ref_pin_clock_select;
	assign gpin_code[1] = dsp_pin_clock_select;
	assign gpin_code[2] = converter_pin_clock_select;
	assign gpin_code[3] = oversample_pin_clock_select;
	assign gpin_code[4] = charge_pump_pin_clock_select;

	for (genvar g = 0; g < 5; g++) begin : g_pin
		csel_pin_mux u_pin (
			.pin_code(gpin_code[g]),
			.gpio0_level(gpio0_s),
			.gpio2_level(gpio2_s),
			.pin_clk(gpin_clk[g]),
			.pin_ok(gpin_ok[g])
		);
	end

	// auto master clock falls back to the oscillator so dividers never starve
	logic master_s;
	assign master_s = ext_clock_valid ? pll_s : osc_s;

	// pll reference
	logic [2:0] ref_code_eff;
	logic [2:0] ref_auto_code;
	logic [1:0] ref_pick;
	assign ref_auto_code = ext_clock_valid ? CSEL_REF_MCLK : CSEL_REF_OSC;
	assign ref_code_eff = clock_auto_set ? ref_auto_code : pll_reference_select;
	assign ref_pick = (ref_code_eff == CSEL_REF_MCLK) ? {1'b1, mclk_s} :
		(ref_code_eff == CSEL_REF_SCLK) ? {1'b1, sclk_s} :
		(ref_code_eff == CSEL_REF_OSC) ? {1'b1, osc_s} :
		(ref_code_eff == CSEL_REF_GPIO) ? {gpin_ok[0], gpin_clk[0] & gpin_ok[0]} : 2'h0;

	// dividers
	logic [1:0] dsp_pick;
	logic [1:0] dac_pick;
	logic [1:0] osr_pick;
	logic [1:0] ncp_pick;
	logic [2:0] osr_shift;
	logic [2:0] ncp_shift;
	assign dsp_pick = pick_div(dsp_divider_source, master_s, pll_s, osc_s, mclk_s, sclk_s,
		gpin_clk[1], gpin_ok[1]);
	assign dac_pick = pick_div(converter_divider_source, master_s, pll_s, osc_s, mclk_s, sclk_s,
		gpin_clk[2], gpin_ok[2]);
	// oversample codes are the divider codes moved up by one, which lets one decoder serve both
	assign osr_shift = 3'(oversample_divider_source - 3'h1);
	assign ncp_shift = 3'(charge_pump_divider_source - 3'h1);
	assign osr_pick = (oversample_divider_source == CSEL_OSR_DAC) ? dac_pick :
		pick_div(osr_shift, master_s, pll_s, osc_s, mclk_s, sclk_s, gpin_clk[3], gpin_ok[3]);
	assign ncp_pick = (charge_pump_divider_source == CSEL_OSR_DAC) ? dac_pick :
		pick_div(ncp_shift, master_s, pll_s, osc_s, mclk_s, sclk_s, gpin_clk[4], gpin_ok[4]);

	// code 111 shifted becomes 110, which pick_div already mutes
	always_ff @(posedge clock) begin
		if (rst) begin
			pll_ref_clk <= 1'b0;
			pll_ref_muted <= 1'b1;
			dsp_div_clk <= 1'b0;
			dsp_div_muted <= 1'b1;
			dac_div_clk <= 1'b0;
			dac_div_muted <= 1'b1;
			oversampling_rate_clock <= 1'b0;
			osr_div_muted <= 1'b1;
			negative_charge_pump_clock <= 1'b0;
			ncp_div_muted <= 1'b1;
		end else begin
			pll_ref_clk <= ref_pick[0];
			pll_ref_muted <= ~ref_pick[1];
			dsp_div_clk <= dsp_pick[0];
			dsp_div_muted <= ~dsp_pick[1];
			dac_div_clk <= dac_pick[0];
			dac_div_muted <= ~dac_pick[1];
			oversampling_rate_clock <= osr_pick[0];
			osr_div_muted <= ~osr_pick[1];
			negative_charge_pump_clock <= ncp_pick[0];
			ncp_div_muted <= ~ncp_pick[1];
		end
	end

	// register port
	always_ff @(posedge clock) begin
		if (rst) begin
			ref_dsp_q <= CSEL_REF_DSP_RST;
			dac_osr_q <= CSEL_DAC_OSR_RST;
			ncp_q <= CSEL_NCP_RST;
			dsp_dac_pin_q <= CSEL_DSP_DAC_PIN_RST;
			ncp_osr_pin_q <= CSEL_NCP_OSR_PIN_RST;
			ref_pin_q <= CSEL_REF_PIN_RST;
		end else if (reg_write) begin
			if (reg_addr == CSEL_REF_DSP_OFS) ref_dsp_q <= reg_wdata;
			if (reg_addr == CSEL_DAC_OSR_OFS) dac_osr_q <= reg_wdata;
			if (reg_addr == CSEL_NCP_OFS) ncp_q <= reg_wdata;
			if (reg_addr == CSEL_DSP_DAC_PIN_OFS) dsp_dac_pin_q <= reg_wdata;
			if (reg_addr == CSEL_NCP_OSR_PIN_OFS) ncp_osr_pin_q <= reg_wdata;
			if (reg_addr == CSEL_REF_PIN_OFS) ref_pin_q <= reg_wdata;
		end
	end

	assign rdata_d = (reg_addr == CSEL_REF_DSP_OFS) ? ref_dsp_q :
		(reg_addr == CSEL_DAC_OSR_OFS) ? dac_osr_q :
		(reg_addr == CSEL_NCP_OFS) ? ncp_q :
		(reg_addr == CSEL_DSP_DAC_PIN_OFS) ? dsp_dac_pin_q :
		(reg_addr == CSEL_NCP_OSR_PIN_OFS) ? ncp_osr_pin_q :
		(reg_addr == CSEL_REF_PIN_OFS) ? ref_pin_q : CSEL_UNMAPPED_RD;

	always_ff @(posedge clock) begin
		if (rst) rdata_q <= CSEL_UNMAPPED_RD;
		else rdata_q <= rdata_d;
	end

	assign reg_rdata = rdata_q;

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	chk_ref_mclk_path: assert property (!clock_auto_set && pll_reference_select == 3'h0 |=>
		pll_ref_clk == $past(mclk_s) && !pll_ref_muted) else $error("ref not master clock pin");
	chk_ref_reserved_mute: assert property (!clock_auto_set && pll_reference_select > 3'h3 |=>
		pll_ref_muted && !pll_ref_clk) else $error("reserved ref code not muted");
	chk_ref_auto_override: assert property (clock_auto_set && !ext_clock_valid |=>
		pll_ref_clk == $past(osc_s) && !pll_ref_muted) else $error("auto mode ref not oscillator");
	chk_dsp_sclk_path: assert property (dsp_divider_source == 3'h4 |=>
		dsp_div_clk == $past(sclk_s)) else $error("dsp divider not bit clock");
	chk_dac_master_auto: assert property (converter_divider_source == 3'h0 && ext_clock_valid |=>
		dac_div_clk == $past(pll_s)) else $error("converter master clock not pll");
	chk_osr_follows_dac: assert property (oversample_divider_source == 3'h0 |=>
		oversampling_rate_clock == dac_div_clk && osr_div_muted == dac_div_muted)
		else $error("oversample not following converter clock");
	chk_ncp_mclk_path: assert property (charge_pump_divider_source == 3'h4 |=>
		negative_charge_pump_clock == $past(mclk_s)) else $error("charge pump not master pin");
	chk_div_reserved_mute: assert property (dsp_divider_source > 3'h5 [*2] |->
		dsp_div_muted && !dsp_div_clk) else $error("reserved divider code not muted");
	sequence s_pin_write;
		reg_write && reg_addr == CSEL_DSP_DAC_PIN_OFS;
	endsequence
	// read data lags the address by one edge, so compare against last cycle's address and contents
	chk_pin_reg_write: assert property (s_pin_write |=> dsp_dac_pin_q == $past(reg_wdata) ##1
		$past(reg_addr) != CSEL_DSP_DAC_PIN_OFS || reg_rdata == $past(dsp_dac_pin_q))
		else $error("pin register write not held");
	chk_pin_gpio2: assert property (oversample_divider_source == 3'h6 && oversample_pin_clock_select == 3'h5 |=>
		oversampling_rate_clock == $past(gpio2_s) && !osr_div_muted) else $error("pin code 5 not pin 2");
	chk_pin_bad_mute: assert property (dsp_divider_source == 3'h5 && dsp_pin_clock_select != 3'h3 &&
		dsp_pin_clock_select != 3'h5 |=> dsp_div_muted) else $error("bad pin code not muted");
	chk_ncp_pin_field: assert property (charge_pump_divider_source == 3'h6 &&
		ncp_osr_pin_q[6:4] == 3'h3 |=> negative_charge_pump_clock == $past(gpio0_s))
		else $error("charge pump pin field misplaced");
	chk_master_fallback: assert property (dsp_divider_source == 3'h0 && !ext_clock_valid |=>
		dsp_div_clk == $past(osc_s)) else $error("master clock fallback wrong");

	// remaining reference codes, and the auto-set pick with a valid external clock
	chk_ref_sclk_path: assert property (!clock_auto_set && pll_reference_select == 3'h1 |=>
		pll_ref_clk == $past(sclk_s) && !pll_ref_muted) else $error("ref not bit clock pin");
	chk_ref_osc_path: assert property (!clock_auto_set && pll_reference_select == 3'h2 |=>
		pll_ref_clk == $past(osc_s) && !pll_ref_muted) else $error("ref not oscillator");
	chk_ref_pin_path: assert property (!clock_auto_set && pll_reference_select == 3'h3 &&
		ref_pin_clock_select == 3'h3 |=> pll_ref_clk == $past(gpio0_s) && !pll_ref_muted)
		else $error("ref not chosen pin");
	chk_ref_auto_mclk: assert property (clock_auto_set && ext_clock_valid |=>
		pll_ref_clk == $past(mclk_s) && !pll_ref_muted) else $error("auto mode ref not master pin");

	// divider sources that the first set of checks leaves open
	chk_dsp_pll_path: assert property (dsp_divider_source == 3'h1 |=>
		dsp_div_clk == $past(pll_s) && !dsp_div_muted) else $error("dsp divider not pll");
	chk_dsp_osc_path: assert property (dsp_divider_source == 3'h2 |=>
		dsp_div_clk == $past(osc_s) && !dsp_div_muted) else $error("dsp divider not oscillator");
	chk_dsp_mclk_path: assert property (dsp_divider_source == 3'h3 |=>
		dsp_div_clk == $past(mclk_s) && !dsp_div_muted) else $error("dsp divider not master pin");
	chk_dac_mclk_path: assert property (converter_divider_source == 3'h3 |=>
		dac_div_clk == $past(mclk_s) && !dac_div_muted) else $error("converter not master pin");
	chk_dac_pin_path: assert property (converter_divider_source == 3'h5 && converter_pin_clock_select == 3'h3 |=>
		dac_div_clk == $past(gpio0_s) && !dac_div_muted) else $error("converter not chosen pin");
	chk_osr_master_auto: assert property (oversample_divider_source == 3'h1 && ext_clock_valid |=>
		oversampling_rate_clock == $past(pll_s) && !osr_div_muted) else $error("oversample master not pll");
	chk_osr_sclk_path: assert property (oversample_divider_source == 3'h5 |=>
		oversampling_rate_clock == $past(sclk_s) && !osr_div_muted) else $error("oversample not bit clock");
	chk_ncp_follows_dac: assert property (charge_pump_divider_source == 3'h0 |=>
		negative_charge_pump_clock == dac_div_clk && ncp_div_muted == dac_div_muted)
		else $error("charge pump not following converter clock");

	// reserved codes on the other three dividers; a muted divider must also see a quiet clock
	chk_dac_reserved_mute: assert property (converter_divider_source > 3'h5 |=>
		dac_div_muted && !dac_div_clk) else $error("reserved converter code not muted");
	chk_osr_reserved_mute: assert property (oversample_divider_source == 3'h7 |=>
		osr_div_muted && !oversampling_rate_clock) else $error("reserved oversample code not muted");
	chk_ncp_reserved_mute: assert property (charge_pump_divider_source == 3'h7 |=>
		ncp_div_muted && !negative_charge_pump_clock) else $error("reserved charge pump code not muted");
endmodule : csel_top
`default_nettype wire

/* bench/csel_top_tb.sv */
// csel_top_tb: directed bench for the clock source selector
// assumes csel_pkg and csel_top compiled first; sources are driven as slow static levels
`default_nettype none
`define CHECK(a, b) check_eq(8'(a), 8'(b))
module csel_top_tb
	import csel_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, rst, reg_write, mclk_pin, sclk_pin, gpio0_pin, gpio2_pin;
	logic internal_oscillator, pll_clk, clock_auto_set, ext_clock_valid;
	logic [7:0] reg_addr, reg_wdata;
	wire logic [7:0] reg_rdata;
	wire logic [4:0] clk_v, mute_v;
	int miscompares = 0;
	int num_checks = 0;

	csel_top dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_rdata(reg_rdata), .mclk_pin(mclk_pin), .sclk_pin(sclk_pin),
		.gpio0_pin(gpio0_pin), .gpio2_pin(gpio2_pin), .internal_oscillator(internal_oscillator),
		.pll_clk(pll_clk), .clock_auto_set(clock_auto_set), .ext_clock_valid(ext_clock_valid),
		.pll_ref_clk(clk_v[0]), .pll_ref_muted(mute_v[0]), .dsp_div_clk(clk_v[1]),
		.dsp_div_muted(mute_v[1]), .dac_div_clk(clk_v[2]), .dac_div_muted(mute_v[2]),
		.oversampling_rate_clock(clk_v[3]), .osr_div_muted(mute_v[3]),
		.negative_charge_pump_clock(clk_v[4]), .ncp_div_muted(mute_v[4]));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task check_eq(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_eq

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		@(posedge clock);
		@(negedge clock);
		`CHECK(reg_rdata, exp);
	endtask : rd

	// source index: 0 master pin, 1 bit clock pin, 2 gpio0, 3 gpio2, 4 oscillator, 5 pll, 7 none
	task set_srcs(input logic [2:0] idx, input logic lvl);
		logic [5:0] v;
		for (int i = 0; i < 6; i++) v[i] = (i == idx) ? lvl : ~lvl;
		@(posedge clock);
		{pll_clk, internal_oscillator, gpio2_pin, gpio0_pin, sclk_pin, mclk_pin} <= v;
	endtask : set_srcs

	// the chosen source toggles against all others, so a wrong pick cannot match by luck
	task probe(input int o, input logic [2:0] idx);
		set_srcs(idx, (idx == 3'h7) ? 1'b0 : 1'b1);
		repeat (5) @(posedge clock);
		@(negedge clock);
		`CHECK({clk_v[o], mute_v[o]}, (idx == 3'h7) ? 2'b01 : 2'b10);
		if (idx != 3'h7) begin
			set_srcs(idx, 1'b0);
			repeat (5) @(posedge clock);
			@(negedge clock);
			`CHECK({clk_v[o], mute_v[o]}, 2'b00);
		end
		// hand back on a rising edge so callers change inputs there
		@(posedge clock);
	endtask : probe

	function automatic logic [2:0] div_src(input logic [2:0] c, input logic [2:0] g);
		case (c)
			3'h0: return ext_clock_valid ? 3'h5 : 3'h4;
			3'h1: return 3'h5;
			3'h2: return 3'h4;
			3'h3: return 3'h0;
			3'h4: return 3'h1;
			3'h5: return g;
			default: return 3'h7;
		endcase
	endfunction : div_src

	task t_reset;
		for (int a = 8'h0d; a <= 8'h12; a++) rd(8'(a), 8'h00);
		rd(8'h13, 8'h00);
		probe(0, 3'h0);
		probe(1, 3'h5);
	endtask : t_reset

	task t_regs;
		wr(8'h10, 8'hff);
		rd(8'h10, 8'hff);
		wr(8'h11, 8'ha5);
		rd(8'h11, 8'ha5);
		wr(8'h20, 8'h55);
		rd(8'h20, 8'h00);
		rd(8'h0d, 8'h00);
	endtask : t_regs

	task t_ref;
		logic [2:0] tab [8] = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h7, 3'h7, 3'h7, 3'h7};
		wr(8'h12, 8'h03);
		for (int c = 0; c < 8; c++) begin
			wr(8'h0d, {1'b0, 3'(c), 4'h0});
			probe(0, tab[c]);
		end
		clock_auto_set <= 1'b1;
		probe(0, 3'h0);
		ext_clock_valid <= 1'b0;
		probe(0, 3'h4);
		clock_auto_set <= 1'b0;
		ext_clock_valid <= 1'b1;
		probe(0, 3'h7);
	endtask : t_ref

	task t_dsp_dac;
		wr(8'h10, 8'h53);
		for (int c = 0; c < 8; c++) begin
			wr(8'h0d, {5'h00, 3'(c)});
			wr(8'h0e, {1'b0, 3'(c), 4'h0});
			probe(1, div_src(3'(c), 3'h3));
			probe(2, div_src(3'(c), 3'h2));
		end
		ext_clock_valid <= 1'b0;
		wr(8'h0d, 8'h00);
		probe(1, 3'h4);
		ext_clock_valid <= 1'b1;
	endtask : t_dsp_dac

	// converter divider parked on the pll so code 000 of the later dividers is recognisable
	task t_osr_ncp;
		logic [2:0] e;
		wr(8'h11, 8'h35);
		for (int c = 0; c < 8; c++) begin
			wr(8'h0e, {4'h1, 1'b0, 3'(c)});
			wr(8'h0f, {5'h00, 3'(c)});
			e = (c == 0) ? 3'h5 : div_src(3'(c - 1), 3'h3);
			probe(3, e);
			e = (c == 0) ? 3'h5 : div_src(3'(c - 1), 3'h2);
			probe(4, e);
		end
		wr(8'h0e, 8'h77);
		probe(2, 3'h7);
		probe(3, 3'h7);
	endtask : t_osr_ncp

	task t_pin_codes;
		wr(8'h0d, 8'h05);
		for (int c = 0; c < 8; c++) begin
			wr(8'h10, {1'b0, 3'(c), 4'h0});
			probe(1, (c == 3) ? 3'h2 : (c == 5) ? 3'h3 : 3'h7);
		end
	endtask : t_pin_codes

	task results;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results

	// under 1000 cycles of work expected; more than twenty times that is a hang
	initial begin
		#2000000;
		miscompares++;
		results();
	end

	initial begin
		rst = 1'b1;
		reg_write = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		{mclk_pin, sclk_pin, gpio0_pin, gpio2_pin, internal_oscillator, pll_clk} = 6'h00;
		clock_auto_set = 1'b0;
		ext_clock_valid = 1'b1;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_ref();
		t_dsp_dac();
		t_osr_ncp();
		t_pin_codes();
		results();
	end
endmodule : csel_top_tb
`default_nettype wire
